// ==== verilog/cpvc_defines.vh ====
// register offsets, field positions and reset values of the csi port/vc bank
`ifndef CPVC_DEFINES_VH
`define CPVC_DEFINES_VH
`define CPVC_ADDR_W          8
`define CPVC_DATA_W          8
`define CPVC_OFF_PORT0_EN    8'h13
`define CPVC_OFF_PORT1_EN    8'h14
`define CPVC_OFF_ROUTING     8'h16
`define CPVC_OFF_VC_SEL      8'h2E
`define CPVC_OFF_IRQ_STAT    8'h30
`define CPVC_OFF_IRQ_MASK    8'h31
`define CPVC_RST_PORT0_EN    8'h3F
`define CPVC_RST_PORT1_EN    8'h00
`define CPVC_RST_ROUTING     8'h02
`define CPVC_RST_VC_SEL      8'h00
`define CPVC_RST_IRQ_MASK    8'h00
`define CPVC_EN_DISABLE      6'h00
`define CPVC_EN_ENABLE       6'h3F
`define CPVC_BIT_RCTL        7
`define CPVC_BIT_TO_PIN3     2
`define CPVC_BIT_TO_PIN0     1
`define CPVC_BIT_IND_STATE   0
`define CPVC_VC_HI           7
`define CPVC_VC_LO           6
`define CPVC_IRQ_W           3
`define CPVC_IRQ_IND_RISE    0
`define CPVC_IRQ_IND_FALL    1
`define CPVC_IRQ_CFG_WRITE   2
`endif

// ==== verilog/cpvc_reg8.v ====
// one eight-bit software register with writable-bit mask and reset value
module cpvc_reg8 #(
	parameter [7:0] RESET_VAL = 8'h00, // value after reset
	parameter [7:0] WR_MASK   = 8'hFF  // bits software may change
) (
	input  wire       core_clk,
	input  wire       reset,
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	output wire [7:0] value
);
	reg [7:0] value_q; // stored contents

	// masked bits stay at reset value, so reserved bits never change
	always @(posedge core_clk)
	begin
		if (reset)
			value_q <= RESET_VAL;
		else if (wr_en)
			value_q <= (wr_data & WR_MASK) | (RESET_VAL & ~WR_MASK);
	end

	assign value = value_q;
endmodule // cpvc_reg8

// ==== verilog/cpvc_event_stat.v ====
// sticky event flags, cleared by a read, with set winning over clear
module cpvc_event_stat #(
	parameter W = 3 // number of event flags
) (
	input  wire         core_clk,
	input  wire         reset,
	input  wire [W-1:0] event_set,
	input  wire         rd_clear,
	output wire [W-1:0] status
);
	reg [W-1:0] status_q; // sticky bits

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_flag
			// a new event in the clearing cycle is kept
			always @(posedge core_clk)
			begin
				if (reset)
					status_q[i] <= 1'b0;
				else if (event_set[i])
					status_q[i] <= 1'b1;
				else if (rd_clear)
					status_q[i] <= 1'b0;
			end
		end
	endgenerate

	assign status = status_q;
endmodule // cpvc_event_stat

// ==== verilog/cpvc_bank.v ====
// csi output port enable, indicator routing and virtual channel register bank
//
// Decided for this implementation: the address-and-strobe port.
`include "cpvc_defines.vh"

//
// Function
// - port zero six-bit enable, resets enabled
// - port one six-bit enable, resets disabled
// - bit seven register control per port
// - routing bit two drives pin three
// - routing bit one drives pin zero
// - routing bit zero reads indicator state
// - bits seven:six give packet virtual channel
module cpvc_bank #(
	parameter AW = `CPVC_ADDR_W, // register address width
	parameter DW = `CPVC_DATA_W  // register data width
) (
	input  wire          core_clk,
	input  wire          reset,
	input  wire [AW-1:0] reg_addr,
	input  wire [DW-1:0] reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [DW-1:0] reg_rdata,
	input  wire          link_indicator,
	output reg  [5:0]    port_zero_enable_field,
	output reg           port_zero_register_control,
	output reg  [5:0]    port_one_enable_field,
	output reg           port_one_register_control,
	output reg           port_zero_active,
	output reg           port_one_active,
	output reg  [1:0]    virtual_channel_code,
	output reg           general_pin_zero,
	output reg           general_pin_zero_oe,
	output reg           general_pin_three,
	output reg           general_pin_three_oe,
	output reg           irq
);
	// address match helper, used for every register
	function hit;
		input [AW-1:0] a;
		input [AW-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// write strobes per register
	wire wr_p0   = reg_wr & hit(reg_addr, `CPVC_OFF_PORT0_EN);
	wire wr_p1   = reg_wr & hit(reg_addr, `CPVC_OFF_PORT1_EN);
	wire wr_rt   = reg_wr & hit(reg_addr, `CPVC_OFF_ROUTING);
	wire wr_vc   = reg_wr & hit(reg_addr, `CPVC_OFF_VC_SEL);
	wire wr_msk  = reg_wr & hit(reg_addr, `CPVC_OFF_IRQ_MASK);
	wire rd_stat = reg_rd & hit(reg_addr, `CPVC_OFF_IRQ_STAT);

	wire [7:0] p0_q;  // port zero enable register
	wire [7:0] p1_q;  // port one enable register
	wire [7:0] rt_q;  // routing register
	wire [7:0] vc_q;  // virtual channel register
	wire [7:0] msk_q; // interrupt mask register

	// bit six reserved, kept at zero
	cpvc_reg8 #(.RESET_VAL(`CPVC_RST_PORT0_EN), .WR_MASK(8'hBF)) u_p0 (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (wr_p0),
		.wr_data  (reg_wdata[7:0]),
		.value    (p0_q)
	);

	cpvc_reg8 #(.RESET_VAL(`CPVC_RST_PORT1_EN), .WR_MASK(8'hBF)) u_p1 (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (wr_p1),
		.wr_data  (reg_wdata[7:0]),
		.value    (p1_q)
	);

	// bit zero is a live status, bits seven:three reserved
	cpvc_reg8 #(.RESET_VAL(`CPVC_RST_ROUTING), .WR_MASK(8'h06)) u_rt (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (wr_rt),
		.wr_data  (reg_wdata[7:0]),
		.value    (rt_q)
	);

	// only the channel code is writable
	cpvc_reg8 #(.RESET_VAL(`CPVC_RST_VC_SEL), .WR_MASK(8'hC0)) u_vc (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (wr_vc),
		.wr_data  (reg_wdata[7:0]),
		.value    (vc_q)
	);

	cpvc_reg8 #(.RESET_VAL(`CPVC_RST_IRQ_MASK), .WR_MASK(8'h07)) u_msk (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (wr_msk),
		.wr_data  (reg_wdata[7:0]),
		.value    (msk_q)
	);

	reg ind_q; // registered indicator, reset low

	// sample indicator for status and edge events
	always @(posedge core_clk)
	begin
		if (reset)
			ind_q <= 1'b0;
		else
			ind_q <= link_indicator;
	end

	// events: indicator rise, fall, configuration write
	wire [`CPVC_IRQ_W-1:0] ev;
	assign ev[`CPVC_IRQ_IND_RISE]  = link_indicator & ~ind_q;
	assign ev[`CPVC_IRQ_IND_FALL]  = ~link_indicator & ind_q;
	assign ev[`CPVC_IRQ_CFG_WRITE] = wr_p0 | wr_p1 | wr_vc;

	wire [`CPVC_IRQ_W-1:0] stat; // sticky status

	cpvc_event_stat #(.W(`CPVC_IRQ_W)) u_stat (
		.core_clk  (core_clk),
		.reset     (reset),
		.event_set (ev),
		.rd_clear  (rd_stat),
		.status    (stat)
	);

	// read data mux, unmapped reads return zero
	reg [7:0] rd_d;
	always @*
	begin
		case (reg_addr)
			`CPVC_OFF_PORT0_EN: rd_d = p0_q;
			`CPVC_OFF_PORT1_EN: rd_d = p1_q;
			`CPVC_OFF_ROUTING:  rd_d = {rt_q[7:1], ind_q};
			`CPVC_OFF_VC_SEL:   rd_d = vc_q;
			`CPVC_OFF_IRQ_STAT: rd_d = {5'h00, stat};
			`CPVC_OFF_IRQ_MASK: rd_d = msk_q;
			default:            rd_d = 8'h00;
		endcase
	end

	// read data valid only the cycle after the strobe
	always @(posedge core_clk)
	begin
		if (reset)
			reg_rdata <= {DW{1'b0}};
		else if (reg_rd)
			reg_rdata <= rd_d; // eight-bit bank, data width stays at eight
		else
			reg_rdata <= {DW{1'b0}};
	end

	// next values of the registered outputs
	wire p0_on = (p0_q[5:0] == `CPVC_EN_ENABLE);
	wire p1_on = (p1_q[5:0] == `CPVC_EN_ENABLE);

	// configuration outputs, pins and interrupt from flip-flops
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			port_zero_enable_field     <= `CPVC_EN_ENABLE;
			port_zero_register_control <= 1'b0;
			port_one_enable_field      <= `CPVC_EN_DISABLE;
			port_one_register_control  <= 1'b0;
			port_zero_active           <= 1'b1;
			port_one_active            <= 1'b0;
			virtual_channel_code       <= 2'h0;
			general_pin_zero           <= 1'b0;
			general_pin_zero_oe        <= 1'b1;
			general_pin_three          <= 1'b0;
			general_pin_three_oe       <= 1'b0;
			irq                        <= 1'b0;
		end
		else
		begin
			port_zero_enable_field     <= p0_q[5:0];
			port_zero_register_control <= p0_q[`CPVC_BIT_RCTL];
			port_one_enable_field      <= p1_q[5:0];
			port_one_register_control  <= p1_q[`CPVC_BIT_RCTL];
			port_zero_active           <= p0_on;
			port_one_active            <= p1_on;
			virtual_channel_code       <= vc_q[`CPVC_VC_HI:`CPVC_VC_LO];
			// indicator routed to pin zero while enabled
			general_pin_zero           <= rt_q[`CPVC_BIT_TO_PIN0] & link_indicator;
			general_pin_zero_oe        <= rt_q[`CPVC_BIT_TO_PIN0];
			// indicator routed to pin three while enabled
			general_pin_three          <= rt_q[`CPVC_BIT_TO_PIN3] & link_indicator;
			general_pin_three_oe       <= rt_q[`CPVC_BIT_TO_PIN3];
			irq                        <= |(stat & msk_q[`CPVC_IRQ_W-1:0]);
		end
	end
endmodule // cpvc_bank

// ==== tb/cpvc_csi_rx.sv ====
// csi receiver model that records the channel of packets from port zero
module cpvc_csi_rx (
	input  wire logic       core_clk,
	input  wire logic       on,
	input  wire logic [1:0] vc,
	output logic      [1:0] rx_vc
);
	timeunit 1ns;
	timeprecision 1ps;
	// take the packet channel while the port is enabled
	always @(posedge core_clk)
		if (on)
			rx_vc <= vc;
endmodule // cpvc_csi_rx

// ==== tb/cpvc_bank_properties.sv ====
// port assertions of the csi port and virtual channel bank
module cpvc_bank_properties (
	input wire       core_clk,
	input wire       reset,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       link_indicator,
	input wire       port_zero_active,
	input wire       port_one_active,
	input wire       port_one_register_control,
	input wire [1:0] virtual_channel_code,
	input wire       general_pin_zero,
	input wire       general_pin_zero_oe,
	input wire       general_pin_three_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	port_zero_on_a: assert property (reg_wr && reg_addr == 8'h13 && reg_wdata[5:0] == 6'h3F
		|=> ##1 port_zero_active) else $error("port zero not on");
	port_one_off_a: assert property (reg_wr && reg_addr == 8'h14 && reg_wdata[5:0] == 6'h00
		|=> ##1 !port_one_active) else $error("port one not off");
	reg_control_a: assert property (reg_wr && reg_addr == 8'h14
		|=> ##1 port_one_register_control == $past(reg_wdata[7], 2)) else $error("bad control");
	pin_three_oe_a: assert property (reg_wr && reg_addr == 8'h16
		|=> ##1 general_pin_three_oe == $past(reg_wdata[2], 2)) else $error("bad pin three");
	pin_zero_val_a: assert property (!$past(reset)
		|-> general_pin_zero == (general_pin_zero_oe && $past(link_indicator)))
		else $error("bad pin zero");
	ind_state_a: assert property (reg_rd && reg_addr == 8'h16 && !$past(reset)
		|=> reg_rdata[0] == $past(link_indicator, 2)) else $error("bad state bit");
	vc_code_a: assert property (reg_wr && reg_addr == 8'h2E
		|=> ##1 virtual_channel_code == $past(reg_wdata[7:6], 2)) else $error("bad channel");
	reserved_zero_a: assert property (reg_rd && reg_addr == 8'h2E
		|=> reg_rdata[5:0] == 6'h00) else $error("reserved not zero");
endmodule // cpvc_bank_properties

bind cpvc_bank cpvc_bank_properties chk (.core_clk(core_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .link_indicator(link_indicator),
	.port_zero_active(port_zero_active), .port_one_active(port_one_active),
	.port_one_register_control(port_one_register_control),
	.virtual_channel_code(virtual_channel_code), .general_pin_zero(general_pin_zero),
	.general_pin_zero_oe(general_pin_zero_oe), .general_pin_three_oe(general_pin_three_oe));

// ==== tb/cpvc_bank_bench.sv ====
// self-checking bench of the csi port and virtual channel bank
module cpvc_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic        link_indicator = 1'h0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, d;
	logic [31:0] seed = 32'hA47C;
	int          compares = 0, miscompares = 0, cycles = 0;
	wire  [7:0]  reg_rdata;
	wire  [1:0]  vc, rx_vc;
	wire         p0a, p1a, p0c, p1c, g0, g0e, g3, g3e, irq;
	logic [7:0]  offs [4] = '{8'h13, 8'h14, 8'h16, 8'h2E};
	logic [7:0]  rsts [4] = '{8'h3F, 8'h00, 8'h02, 8'h00};
	always #2.5 core_clk = ~core_clk;
	cpvc_bank dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_indicator(link_indicator), .port_zero_enable_field(),
		.port_zero_register_control(p0c), .port_one_enable_field(),
		.port_one_register_control(p1c), .port_zero_active(p0a), .port_one_active(p1a),
		.virtual_channel_code(vc), .general_pin_zero(g0), .general_pin_zero_oe(g0e),
		.general_pin_three(g3), .general_pin_three_oe(g3e), .irq(irq));
	cpvc_csi_rx rx (.core_clk(core_clk), .on(p0a), .vc(vc), .rx_vc(rx_vc));
	// xorshift source of random register values
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// readback value once reserved bits are dropped
	function automatic logic [7:0] expv(input logic [7:0] a, input logic [7:0] v);
		case (a)
			8'h13, 8'h14: return v & 8'hBF;
			8'h2E: return v & 8'hC0;
			default: return v & 8'h06;
		endcase
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
		compares++;
		if (v !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 chk("read", e, reg_rdata);
	endtask
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			finish_test();
		end
	end
	initial
	begin
		repeat (6) @(posedge core_clk);
		reset <= 1'h0;
		for (int i = 0; i < 4; i++)
			rd(offs[i], rsts[i]);
		wr(8'h31, 8'h01);
		link_indicator <= 1'h1;
		repeat (4) step();
		chk("irq", 8'h01, {7'h00, irq});
		rd(8'h30, 8'h01);
		repeat (2) step();
		chk("irq", 8'h00, {7'h00, irq});
		rd(8'h40, 8'h00);
		for (int v = 0; v < 2; v++)
		begin
			wr(8'h16, 8'h06);
			link_indicator <= v[0];
			repeat (2) step();
			chk("pins", {4'h5, 1'h0, v[0], 1'h0, v[0]}, {1'h0, g3e, 1'h0, g0e, 1'h0, g3, 1'h0, g0});
			rd(8'h16, {7'h03, v[0]});
		end
		wr(8'h13, 8'h80);
		step();
		chk("port zero", 8'h02, {6'h00, p0c, p0a});
		wr(8'h14, 8'hFF);
		step();
		chk("port one", 8'h03, {6'h00, p1c, p1a});
		link_indicator <= 1'h0;
		for (int i = 0; i < 12; i++)
		begin
			d = rnd();
			wr(offs[i % 4], d);
			rd(offs[i % 4], expv(offs[i % 4], d));
		end
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h2E, {c[1:0], 6'h3F});
			wr(8'h13, 8'h3F);
			repeat (2) step();
			chk("channel", {6'h00, c[1:0]}, {6'h00, rx_vc});
		end
		rd(8'h30, 8'h07);
		finish_test();
	end
endmodule // cpvc_bank_bench
